/* File: hdl/framer_pkg.sv */
// Shared constants and state types of the multi-drop command framer.
package framer_pkg;
   // ==========================================================
   // Link control characters.
   localparam logic [7:0] CH_AT = 8'h40;
   localparam logic [7:0] CH_STX = 8'h02;
   localparam logic [7:0] CH_ETX = 8'h03;
   localparam logic [7:0] CH_ETB = 8'h17;
   localparam logic [7:0] CH_ACK = 8'h06;
   localparam logic [7:0] CH_NAK = 8'h15;
   localparam logic [7:0] CH_CTRL = 8'h20;
   localparam logic [7:0] CH_QUERY = 8'h3f;
   localparam logic [7:0] CH_OK = 8'h23;
   localparam logic [7:0] CH_FAIL = 8'h21;
   localparam logic [7:0] CH_ZERO = 8'h30;
   localparam logic [7:0] CH_FN_RUN = 8'h45;
   // ==========================================================
   // Counts and reset values.
   localparam logic [7:0] LRC_INIT = 8'hff;
   localparam logic [8:0] MSG_MAX = 9'h0ff;
   localparam logic [2:0] RETRY_MAX = 3'h5;
   localparam logic [11:0] BLK_FIRST = 12'h001;
   localparam logic [15:0] PAR_START = 16'h3031;
   localparam logic [15:0] PAR_STOP = 16'h3032;
   localparam int FIFO_WIDTH = 9;
   localparam int FIFO_DEPTH = 16;
   localparam logic [2:0] HDR_LAST = 3'h6;
   // ==========================================================
   // State types.
   typedef enum logic [2:0] {R_IDLE, R_AH, R_AL, R_STX, R_BN, R_MSG, R_LRC} rx_state_e;
   typedef enum logic [2:0] {T_IDLE, T_ACK, T_RWAIT, T_HDR, T_MSG, T_LRC, T_HWAIT} tx_state_e;
endpackage

/* File: hdl/byte_fifo.sv */
// Parameterised first-in first-out buffer with valid/ready on both sides.
`timescale 1ns/10ps
module byte_fifo #(
   parameter int WIDTH = 9,
   parameter int DEPTH = 16
) (
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic in_valid_i,
   input wire logic [WIDTH-1:0] in_data_i,
   output logic in_ready_o,
   output logic out_valid_o,
   output logic [WIDTH-1:0] out_data_o,
   input wire logic out_ready_i,
   output logic [$clog2(DEPTH):0] level_o
);
   localparam int AW = $clog2(DEPTH);
   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [AW-1:0] wr;
      logic [AW-1:0] rd;
      logic [AW:0] cnt;
   } fifo_s;
   fifo_s st_ff, nxt_st;
   logic push, pop;

   // Full and empty come from the stored count, so they never lie.
   assign in_ready_o = (st_ff.cnt != (AW+1)'(DEPTH));
   assign out_valid_o = (st_ff.cnt != '0);
   assign out_data_o = st_ff.mem[st_ff.rd];
   assign level_o = st_ff.cnt;
   assign push = in_valid_i && in_ready_o;
   assign pop = out_valid_o && out_ready_i;

   // Pointer and count update for one push and one pop per cycle.
   always_comb begin
      nxt_st = st_ff;
      if (push) begin
         nxt_st.mem[st_ff.wr] = in_data_i;
         nxt_st.wr = st_ff.wr + 1'b1;
      end
      if (pop) begin
         nxt_st.rd = st_ff.rd + 1'b1;
      end
      nxt_st.cnt = st_ff.cnt + (AW+1)'(push) - (AW+1)'(pop);
   end

   // State register.
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         st_ff <= '0;
      end else begin
         st_ff <= nxt_st;
      end
   end
endmodule

/* File: hdl/multidrop_ascii_command_framer.sv */
// Device-side framer for the addressed multi-drop ASCII command link.
// Functional notes
// - Block is @, two node chars, STX, three block digits, message, end, checksum.
// - A full 255-character block that is not last ends with ETB.
// - The last or only block ends with ETX.
// - Blocks numbered from 001 upward; non-final blocks hold exactly 255 characters.
// - Control message starts with space, then function code, then parameters.
// - Parameters are 16-bit signed values written as hex ASCII.
// - Lead and function code appear only in the first block.
// - Reply carries # on success, or ! plus a three-character code; a successful query reply carries space and function code instead of #.
// - Device answers each block addressed to its own node with ACK or NAK plus its node chars.
// - Query message starts with question mark, then function code, then parameters.
// - Long reply: next block only after host ACK; final block ends with ETX.
// - Node number 00 start or stop commands are obeyed by every device.
// - Broadcast frames get no acknowledge and no response.
// - Broadcast uses function E with one 8-bit hex parameter, 1 start, 2 stop.
// - Checksum starts at FF and XORs every frame byte including controls.
// - On NAK the same block is sent again, at most five times.
// - Node numbers run 1 to 127, written as two upper-case hex chars.
`timescale 1ns/10ps
module multidrop_ascii_command_framer (
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic [6:0] node_id_i,
   input wire logic rx_valid_i,
   input wire logic [7:0] rx_data_i,
   output logic rx_ready_o,
   output logic tx_valid_o,
   output logic [7:0] tx_data_o,
   input wire logic tx_ready_i,
   output logic par_valid_o,
   output logic [framer_pkg::FIFO_WIDTH-1:0] par_data_o,
   input wire logic par_ready_i,
   output logic cmd_done_o,
   output logic cmd_query_o,
   output logic [7:0] function_code_char_o,
   output logic blk_bad_o,
   output logic run_start_o,
   output logic run_stop_o,
   input wire logic rsp_go_i,
   input wire logic rsp_ok_i,
   input wire logic [23:0] rsp_code_i,
   input wire logic rsp_valid_i,
   input wire logic [7:0] rsp_data_i,
   input wire logic rsp_last_i,
   output logic rsp_ready_o,
   output logic rsp_replay_o,
   output logic tx_fail_o
);
   import framer_pkg::*;

   // ==========================================================
   // Helper functions.
   // Upper-case hex character to nibble, bit 4 flags a legal character.
   function automatic logic [4:0] hex2nib(input logic [7:0] c);
      logic [4:0] r;
      r = '0;
      if (c >= 8'h30 && c <= 8'h39) begin
         r = {1'b1, c[3:0]};
      end else if (c >= 8'h41 && c <= 8'h46) begin
         r = {1'b1, c[3:0] + 4'h9};
      end
      return r;
   endfunction

   // Nibble to upper-case hex character.
   function automatic logic [7:0] nib2hex(input logic [3:0] n);
      return (n < 4'ha) ? (CH_ZERO + {4'h0, n}) : (8'h37 + {4'h0, n});
   endfunction

   // Three-digit decimal block counter increment.
   function automatic logic [11:0] bcd_inc(input logic [11:0] b);
      logic [11:0] r;
      r = b;
      if (b[3:0] != 4'h9) begin
         r[3:0] = b[3:0] + 4'h1;
      end else begin
         r[3:0] = 4'h0;
         if (b[7:4] != 4'h9) begin
            r[7:4] = b[7:4] + 4'h1;
         end else begin
            r[7:4] = 4'h0;
            r[11:8] = b[11:8] + 4'h1;
         end
      end
      return r;
   endfunction

   // ==========================================================
   // State.
   typedef struct packed {
      rx_state_e rst;
      logic [3:0] ahi;
      logic mine;
      logic bcast;
      logic [1:0] bidx;
      logic [11:0] rbnum;
      logic [11:0] rexp;
      logic [7:0] rlrc;
      logic [8:0] rcnt;
      logic [7:0] lead;
      logic [7:0] func;
      logic [15:0] par;
      logic rbad;
      logic retx;
      logic rx_ready;
      tx_state_e tst;
      logic [2:0] tidx;
      logic [11:0] tbnum;
      logic [7:0] tlrc;
      logic [8:0] tcnt;
      logic [2:0] hidx;
      logic last_seen;
      logic last_blk;
      logic [2:0] retry;
      logic ok;
      logic query;
      logic [23:0] code;
      logic ack_req;
      logic [7:0] ack_byte;
      logic resp_due;
      logic tx_valid;
      logic [7:0] tx_data;
      logic rsp_ready;
      logic cmd_done;
      logic blk_bad;
      logic run_start;
      logic run_stop;
      logic replay;
      logic tx_fail;
   } st_s;
   st_s st_ff, nxt_st;
   logic rx_take, fifo_push, fifo_rdy, host_ack, host_nak, slot_free;
   logic [FIFO_WIDTH-1:0] fifo_din;
   logic [4:0] fifo_lvl;
   logic [2:0] head_len;
   logic [7:0] head_byte, hdr_byte;

   assign rx_take = rx_valid_i && st_ff.rx_ready;
   assign slot_free = !st_ff.tx_valid || tx_ready_i;
   // Host answers to a response block are decoded from the ACK or NAK character alone; any node characters after it are ignored.
   assign host_ack = rx_take && st_ff.rst == R_IDLE && rx_data_i == CH_ACK;
   assign host_nak = rx_take && st_ff.rst == R_IDLE && rx_data_i == CH_NAK;

   // ==========================================================
   // Parameter buffer toward the command executor.
   byte_fifo #(.WIDTH(FIFO_WIDTH), .DEPTH(FIFO_DEPTH)) par_fifo (
      .clk_i(clk_i),
      .rst_n_i(rst_n_i),
      .in_valid_i(fifo_push),
      .in_data_i(fifo_din),
      .in_ready_o(fifo_rdy),
      .out_valid_o(par_valid_o),
      .out_data_o(par_data_o),
      .out_ready_i(par_ready_i),
      .level_o(fifo_lvl)
   );

   // Reply head characters, then transmit header characters.
   always_comb begin
      head_len = !st_ff.ok ? 3'h4 : (st_ff.query ? 3'h2 : 3'h1);
      head_byte = CH_OK;
      if (!st_ff.ok) begin
         unique case (st_ff.hidx)
            3'h0: head_byte = CH_FAIL;
            3'h1: head_byte = st_ff.code[23:16];
            3'h2: head_byte = st_ff.code[15:8];
            default: head_byte = st_ff.code[7:0];
         endcase
      end else if (st_ff.query) begin
         head_byte = (st_ff.hidx == 3'h0) ? CH_CTRL : st_ff.func;
      end
      unique case (st_ff.tidx)
         3'h0: hdr_byte = CH_AT;
         3'h1: hdr_byte = nib2hex({1'b0, node_id_i[6:4]});
         3'h2: hdr_byte = nib2hex(node_id_i[3:0]);
         3'h3: hdr_byte = CH_STX;
         3'h4: hdr_byte = CH_ZERO | {4'h0, st_ff.tbnum[11:8]};
         3'h5: hdr_byte = CH_ZERO | {4'h0, st_ff.tbnum[7:4]};
         default: hdr_byte = CH_ZERO | {4'h0, st_ff.tbnum[3:0]};
      endcase
   end

   // ==========================================================
   // Receive and transmit engines, one next-state process.
   always_comb begin
      logic [4:0] nh;
      logic good, first;
      nxt_st = st_ff;
      nh = hex2nib(rx_data_i);
      good = 1'b0;
      first = (st_ff.rexp == BLK_FIRST);
      fifo_push = 1'b0;
      fifo_din = {(st_ff.rcnt == (first ? 9'h002 : 9'h000)), rx_data_i};
      {nxt_st.cmd_done, nxt_st.blk_bad, nxt_st.run_start, nxt_st.run_stop} = 4'h0;
      {nxt_st.replay, nxt_st.tx_fail} = 2'h0;
      // One free slot is kept because this ready is a cycle late.
      nxt_st.rx_ready = (fifo_lvl < 5'(FIFO_DEPTH - 1));
      if (rx_take) begin
         nxt_st.rlrc = st_ff.rlrc ^ rx_data_i;
         unique case (st_ff.rst)
            R_IDLE: begin
               if (rx_data_i == CH_AT) begin
                  nxt_st.rst = R_AH;
                  nxt_st.rlrc = LRC_INIT ^ CH_AT;
                  nxt_st.rbad = 1'b0;
               end
            end
            R_AH: begin
               nxt_st.ahi = nh[3:0];
               nxt_st.rbad = !nh[4] || nh[3];
               nxt_st.rst = R_AL;
            end
            R_AL: begin
               nxt_st.bcast = !st_ff.rbad && nh[4] && {st_ff.ahi, nh[3:0]} == 8'h00;
               nxt_st.mine = !st_ff.rbad && nh[4] && {st_ff.ahi, nh[3:0]} == {1'b0, node_id_i};
               nxt_st.rst = R_STX;
            end
            R_STX: begin
               // Frames for other nodes are tracked to their end but never answered.
               nxt_st.rbad = (rx_data_i != CH_STX);
               nxt_st.rst = R_BN;
               nxt_st.bidx = 2'h0;
               nxt_st.rcnt = '0;
            end
            R_BN: begin
               nxt_st.rbnum = {st_ff.rbnum[7:0], rx_data_i[3:0]};
               if (!nh[4] || nh[3:0] > 4'h9) begin
                  nxt_st.rbad = 1'b1;
               end
               nxt_st.bidx = st_ff.bidx + 2'h1;
               if (st_ff.bidx == 2'h2) begin
                  nxt_st.rst = R_MSG;
               end
            end
            R_MSG: begin
               if (rx_data_i == CH_ETB || rx_data_i == CH_ETX) begin
                  nxt_st.retx = (rx_data_i == CH_ETX);
                  // A non-final block must be exactly full.
                  if (rx_data_i == CH_ETB && st_ff.rcnt != MSG_MAX) begin
                     nxt_st.rbad = 1'b1;
                  end
                  nxt_st.rst = R_LRC;
               end else if (st_ff.rcnt == MSG_MAX) begin
                  nxt_st.rbad = 1'b1;
               end else begin
                  nxt_st.rcnt = st_ff.rcnt + 9'h001;
                  nxt_st.par = {st_ff.par[7:0], rx_data_i};
                  if (first && st_ff.rcnt == 9'h000) begin
                     nxt_st.lead = rx_data_i;
                     nxt_st.rbad = st_ff.rbad || !(rx_data_i == CH_CTRL
                        || rx_data_i == CH_QUERY);
                  end else if (first && st_ff.rcnt == 9'h001) begin
                     nxt_st.func = rx_data_i;
                  end else if (st_ff.mine) begin
                     fifo_push = fifo_rdy;
                  end
               end
            end
            R_LRC: begin
               good = (st_ff.rlrc == rx_data_i) && !st_ff.rbad
                  && st_ff.rbnum == st_ff.rexp;
               nxt_st.rst = R_IDLE;
               if (st_ff.bcast) begin
                  // Broadcast: act on start or stop, never answer.
                  if (good && st_ff.retx && first && st_ff.lead == CH_CTRL
                      && st_ff.func == CH_FN_RUN && st_ff.rcnt == 9'h004) begin
                     nxt_st.run_start = (st_ff.par == PAR_START);
                     nxt_st.run_stop = (st_ff.par == PAR_STOP);
                  end
               end else if (st_ff.mine) begin
                  nxt_st.ack_req = 1'b1;
                  nxt_st.ack_byte = good ? CH_ACK : CH_NAK;
                  nxt_st.blk_bad = !good;
                  if (good && st_ff.retx) begin
                     nxt_st.rexp = BLK_FIRST;
                     nxt_st.cmd_done = 1'b1;
                     nxt_st.resp_due = 1'b1;
                  end else if (good) begin
                     nxt_st.rexp = bcd_inc(st_ff.rexp);
                  end
               end
            end
            default: nxt_st.rst = R_IDLE;
         endcase
      end
      // Transmit side; a byte leaves when the sink takes it.
      if (st_ff.tx_valid && tx_ready_i) begin
         nxt_st.tx_valid = 1'b0;
      end
      if (st_ff.rsp_ready && rsp_valid_i) begin
         nxt_st.rsp_ready = 1'b0;
      end
      unique case (st_ff.tst)
         T_IDLE: begin
            if (st_ff.ack_req && slot_free) begin
               nxt_st.tx_valid = 1'b1;
               nxt_st.tx_data = st_ff.ack_byte;
               nxt_st.ack_req = 1'b0;
               nxt_st.tidx = 3'h1;
               nxt_st.tst = T_ACK;
            end
         end
         T_ACK: begin
            if (slot_free) begin
               nxt_st.tx_valid = 1'b1;
               nxt_st.tx_data = hdr_byte;
               nxt_st.tidx = st_ff.tidx + 3'h1;
               if (st_ff.tidx == 3'h2) begin
                  nxt_st.tst = st_ff.resp_due ? T_RWAIT : T_IDLE;
               end
            end
         end
         T_RWAIT: begin
            if (rsp_go_i) begin
               nxt_st.resp_due = 1'b0;
               nxt_st.ok = rsp_ok_i;
               nxt_st.query = (st_ff.lead == CH_QUERY);
               nxt_st.code = rsp_code_i;
               nxt_st.tbnum = BLK_FIRST;
               nxt_st.retry = '0;
               nxt_st.hidx = '0;
               nxt_st.last_seen = 1'b0;
               nxt_st.tidx = '0;
               nxt_st.tlrc = LRC_INIT;
               nxt_st.tst = T_HDR;
            end
         end
         T_HDR: begin
            if (slot_free) begin
               nxt_st.tx_valid = 1'b1;
               nxt_st.tx_data = hdr_byte;
               nxt_st.tlrc = st_ff.tlrc ^ hdr_byte;
               nxt_st.tidx = st_ff.tidx + 3'h1;
               nxt_st.tcnt = '0;
               if (st_ff.tidx == HDR_LAST) begin
                  nxt_st.tst = T_MSG;
               end
            end
         end
         T_MSG: begin
            if (st_ff.rsp_ready && rsp_valid_i) begin
               nxt_st.tx_valid = 1'b1;
               nxt_st.tx_data = rsp_data_i;
               nxt_st.tlrc = st_ff.tlrc ^ rsp_data_i;
               nxt_st.tcnt = st_ff.tcnt + 9'h001;
               nxt_st.last_seen = rsp_last_i;
            end else if (slot_free && !st_ff.rsp_ready) begin
               if (st_ff.tbnum == BLK_FIRST && st_ff.hidx < head_len) begin
                  nxt_st.tx_valid = 1'b1;
                  nxt_st.tx_data = head_byte;
                  nxt_st.tlrc = st_ff.tlrc ^ head_byte;
                  nxt_st.hidx = st_ff.hidx + 3'h1;
                  nxt_st.tcnt = st_ff.tcnt + 9'h001;
               end else if (st_ff.ok && st_ff.query && !st_ff.last_seen
                            && st_ff.tcnt != MSG_MAX) begin
                  nxt_st.rsp_ready = 1'b1;
               end else begin
                  // Data still pending means a full block, which ends in ETB.
                  nxt_st.last_blk = !(st_ff.ok && st_ff.query) || st_ff.last_seen;
                  nxt_st.tx_valid = 1'b1;
                  nxt_st.tx_data = nxt_st.last_blk ? CH_ETX : CH_ETB;
                  nxt_st.tlrc = st_ff.tlrc ^ nxt_st.tx_data;
                  nxt_st.tst = T_LRC;
               end
            end
         end
         T_LRC: begin
            if (slot_free) begin
               nxt_st.tx_valid = 1'b1;
               nxt_st.tx_data = st_ff.tlrc;
               nxt_st.tst = T_HWAIT;
            end
         end
         T_HWAIT: begin
            nxt_st.tidx = '0;
            nxt_st.tlrc = LRC_INIT;
            if (host_ack) begin
               nxt_st.retry = '0;
               nxt_st.tbnum = bcd_inc(st_ff.tbnum);
               nxt_st.tst = st_ff.last_blk ? T_IDLE : T_HDR;
            end else if (host_nak && st_ff.retry != RETRY_MAX) begin
               // The executor rewinds its data to the start of this block.
               nxt_st.retry = st_ff.retry + 3'h1;
               nxt_st.replay = 1'b1;
               nxt_st.hidx = '0;
               nxt_st.last_seen = 1'b0;
               nxt_st.tst = T_HDR;
            end else if (host_nak) begin
               nxt_st.tx_fail = 1'b1;
               nxt_st.tst = T_IDLE;
            end
         end
         default: nxt_st.tst = T_IDLE;
      endcase
   end

   // State register; after reset the first command block must carry number 001.
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         st_ff <= '0;
         st_ff.rexp <= BLK_FIRST;
      end else begin
         st_ff <= nxt_st;
      end
   end

   // Outputs straight from the state register; cmd_query_o is decoded from the stored lead character.
   assign rx_ready_o = st_ff.rx_ready;
   assign tx_valid_o = st_ff.tx_valid;
   assign tx_data_o = st_ff.tx_data;
   assign cmd_done_o = st_ff.cmd_done;
   assign cmd_query_o = (st_ff.lead == CH_QUERY);
   assign function_code_char_o = st_ff.func;
   assign blk_bad_o = st_ff.blk_bad;
   assign run_start_o = st_ff.run_start;
   assign run_stop_o = st_ff.run_stop;
   assign rsp_ready_o = st_ff.rsp_ready;
   assign rsp_replay_o = st_ff.replay;
   assign tx_fail_o = st_ff.tx_fail;

   // ==========================================================
   // Assertions and cover points.
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);

   chk_block_start_at: assert property (
      st_ff.tst == T_HDR && st_ff.tidx == 3'h1 |-> tx_valid_o && tx_data_o == CH_AT)
      else $error("Response block does not open with the at-sign.");
   chk_etb_full_block: assert property (
      st_ff.tst == T_LRC && tx_data_o == CH_ETB |-> st_ff.tcnt == MSG_MAX)
      else $error("ETB sent on a block that is not full.");
   chk_etx_last_block: assert property (
      st_ff.tst == T_LRC && tx_data_o == CH_ETX |-> !(st_ff.ok && st_ff.query)
      || st_ff.last_seen)
      else $error("ETX sent while reply data remains.");
   chk_result_char: assert property (
      st_ff.tst == T_MSG && st_ff.hidx == 3'h1 && st_ff.tbnum == BLK_FIRST
      |-> tx_data_o == (st_ff.ok ? (st_ff.query ? CH_CTRL : CH_OK) : CH_FAIL))
      else $error("Wrong result character.");
   chk_ack_node_chars: assert property (
      st_ff.tst == T_ACK && st_ff.tidx == 3'h1 && tx_ready_i
      |=> tx_valid_o && tx_data_o == nib2hex({1'b0, node_id_i[6:4]}))
      else $error("ACK not followed by node character.");
   chk_bcast_silent: assert property (
      rx_take && st_ff.rst == R_LRC && st_ff.bcast |=> !st_ff.ack_req [*3])
      else $error("Broadcast frame was answered.");
   chk_other_node: assert property (
      rx_take && st_ff.rst == R_LRC && !st_ff.mine && !st_ff.ack_req |=> !st_ff.ack_req)
      else $error("Frame for another node was answered.");
   chk_retry_limit: assert property (
      host_nak && st_ff.tst == T_HWAIT && st_ff.retry == RETRY_MAX
      |=> st_ff.tst == T_IDLE && tx_fail_o && !rsp_replay_o)
      else $error("Retry limit not enforced.");
   chk_next_block_ack: assert property (
      st_ff.tst == T_HWAIT && !host_ack && !host_nak |=> st_ff.tst == T_HWAIT)
      else $error("Next block sent without host answer.");
   chk_start_payload: assert property (
      run_start_o |-> $past(st_ff.par) == PAR_START && $past(st_ff.func) == CH_FN_RUN)
      else $error("Start pulse without start parameter.");

   cov_bcast_start: cover property (run_start_o);
   cov_cmd_done: cover property (cmd_done_o);
   cov_replay: cover property (rsp_replay_o);
   cov_etb_sent: cover property (st_ff.tst == T_LRC && tx_data_o == CH_ETB);
endmodule

/* File: verification/link_host.sv */
// Host-side link sink that collects every byte the framer transmits.
`timescale 1ns/10ps
module link_host (
   input wire logic clk_i,
   input wire logic slow_i,
   input wire logic tx_valid_i,
   input wire logic [7:0] tx_data_i,
   output logic tx_ready_o
);
   logic [7:0] got[$];
   // Takes a byte on valid and ready; a slow host stalls every other cycle.
   always @(posedge clk_i) begin
      if (tx_valid_i && tx_ready_o) got.push_back(tx_data_i);
      tx_ready_o <= slow_i ? !tx_ready_o : 1'b1;
   end
   initial tx_ready_o = 1'b0;
endmodule

/* File: verification/multidrop_ascii_command_framer_test.sv */
// Self-checking bench of the multi-drop command framer.
`timescale 1ns/10ps
module multidrop_ascii_command_framer_test;
   import framer_pkg::*;
   typedef logic [7:0] bq_t[$];
   logic clk_i = 1'b0, rst_n_i = 1'b0, rx_valid_i = 1'b0, rsp_go_i = 1'b0, rsp_ok_i = 1'b0;
   logic slow = 1'b0, tx_ready_i, rx_ready_o, tx_valid_o, done, query, start, stop, bad;
   logic rsp_valid_i = 1'b0, rsp_last_i = 1'b0, rsp_ready_o, rep, fail, pv;
   logic [7:0] rx_data_i = 8'h00, rsp_data_i = 8'h00, tx_data_o, fc;
   logic [8:0] pd, pq[$];
   int n_mismatch = 0, tests_run = 0, n_done = 0, n_bad = 0, n_start = 0, n_stop = 0;
   int n_rep = 0, n_fail = 0;
   multidrop_ascii_command_framer i_multidrop_ascii_command_framer (.clk_i(clk_i),
      .rst_n_i(rst_n_i), .node_id_i(7'h05), .rx_valid_i(rx_valid_i), .rx_data_i(rx_data_i),
      .rx_ready_o(rx_ready_o), .tx_valid_o(tx_valid_o), .tx_data_o(tx_data_o),
      .tx_ready_i(tx_ready_i), .par_valid_o(pv), .par_data_o(pd), .par_ready_i(1'b1),
      .cmd_done_o(done), .cmd_query_o(query), .function_code_char_o(fc), .blk_bad_o(bad),
      .run_start_o(start), .run_stop_o(stop), .rsp_go_i(rsp_go_i), .rsp_ok_i(rsp_ok_i),
      .rsp_code_i(24'h303132), .rsp_valid_i(rsp_valid_i), .rsp_data_i(rsp_data_i),
      .rsp_last_i(rsp_last_i), .rsp_ready_o(rsp_ready_o), .rsp_replay_o(rep),
      .tx_fail_o(fail));
   link_host i_link_host (.clk_i(clk_i), .slow_i(slow), .tx_valid_i(tx_valid_o),
      .tx_data_i(tx_data_o), .tx_ready_o(tx_ready_i));
   always #5 clk_i = ~clk_i;
   // Counts the one-cycle pulses so scenarios can judge them afterwards.
   always @(posedge clk_i) begin
      n_done += (done === 1'b1);
      n_bad += (bad === 1'b1);
      n_start += (start === 1'b1);
      n_stop += (stop === 1'b1);
      n_rep += (rep === 1'b1);
      n_fail += (fail === 1'b1);
      if (pv === 1'b1) pq.push_back(pd);
   end
   task automatic end_sim();
      if (n_mismatch == 0 && tests_run > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      tests_run++;
      if (got !== exp) begin
         n_mismatch++;
         $display("mismatch %0t got %h exp %h", $time, got, exp);
      end
   endtask
   // Builds one block numbered 001 with its checksum over all bytes.
   function automatic bq_t frm(input logic [7:0] f1, f2, e, input string m);
      bq_t s;
      logic [7:0] l;
      s = '{CH_AT, f1, f2, CH_STX, CH_ZERO, CH_ZERO, 8'h31};
      foreach (m[i]) s.push_back(m[i]);
      s.push_back(e);
      l = LRC_INIT;
      foreach (s[i]) l ^= s[i];
      s.push_back(l);
      return s;
   endfunction
   // Sends bytes back to back, each held until the framer is ready.
   task automatic send(input bq_t s);
      foreach (s[i]) begin
         rx_data_i <= s[i];
         rx_valid_i <= 1'b1;
         @(negedge clk_i);
         while (rx_ready_o !== 1'b1) @(negedge clk_i);
         @(posedge clk_i);
      end
      rx_valid_i <= 1'b0;
      @(posedge clk_i);
   endtask
   // Offers reply data bytes, each held until the framer takes it.
   task automatic stream(input string m);
      for (int i = 0; i < m.len(); i++) begin
         rsp_data_i <= m[i];
         rsp_last_i <= (i == m.len() - 1);
         rsp_valid_i <= 1'b1;
         @(negedge clk_i);
         while (rsp_ready_o !== 1'b1) @(negedge clk_i);
         @(posedge clk_i);
      end
      rsp_valid_i <= 1'b0;
   endtask
   task automatic expect_tx(input bq_t x);
      for (int k = 0; k < 300 && i_link_host.got.size() < x.size(); k++) @(posedge clk_i);
      repeat (20) @(posedge clk_i);
      chk(8'(i_link_host.got.size()), 8'(x.size()));
      foreach (x[i]) chk(i_link_host.got[i], x[i]);
      i_link_host.got.delete();
   endtask
   // Hands over the result, checks the reply block, NAKs it naks times, then ACKs it.
   task automatic respond(input logic ok, input string m, input string d, input int naks);
      bq_t x;
      x = frm(8'h30, 8'h35, CH_ETX, m);
      rsp_ok_i <= ok;
      rsp_go_i <= 1'b1;
      @(posedge clk_i);
      rsp_go_i <= 1'b0;
      fork
         stream(d);
         expect_tx(x);
      join
      for (int k = 1; k <= naks; k++) begin
         send('{CH_NAK, 8'h30, 8'h35});
         if (k > RETRY_MAX) x.delete();
         expect_tx(x);
      end
      send('{CH_ACK, 8'h30, 8'h35});
   endtask
   task automatic s_ctrl();
      slow <= 1'b1;
      send(frm(8'h30, 8'h35, CH_ETX, " h01"));
      expect_tx('{CH_ACK, 8'h30, 8'h35});
      chk(8'(pq.size()), 8'h02);
      chk(pq[0][7:0], 8'h30);
      chk(8'(pq[0][8]), 8'h01);
      chk(8'(n_done), 8'h01);
      chk(fc, 8'h68);
      chk({7'h00, query}, 8'h00);
      respond(1'b1, "#", "", 0);
      slow <= 1'b0;
   endtask
   task automatic s_query();
      send(frm(8'h30, 8'h35, CH_ETX, "?M"));
      expect_tx('{CH_ACK, 8'h30, 8'h35});
      chk({7'h00, query}, 8'h01);
      chk(fc, 8'h4d);
      respond(1'b0, "!012", "", 0);
   endtask
   task automatic s_bad();
      bq_t s;
      s = frm(8'h30, 8'h35, CH_ETX, " h02");
      s[s.size() - 1] ^= 8'h01;
      send(s);
      expect_tx('{CH_NAK, 8'h30, 8'h35});
      chk(8'(n_bad), 8'h01);
      chk(8'(n_done), 8'h02);
   endtask
   task automatic s_bcast();
      send(frm(CH_ZERO, CH_ZERO, CH_ETX, " E01"));
      send(frm(CH_ZERO, CH_ZERO, CH_ETX, " E02"));
      expect_tx('{});
      chk(8'(n_start), 8'h01);
      chk(8'(n_stop), 8'h01);
   endtask
   task automatic s_other();
      send(frm(8'h30, 8'h36, CH_ETX, " h01"));
      expect_tx('{});
      chk(8'(n_done), 8'h02);
   endtask
   task automatic s_qok();
      send(frm(8'h30, 8'h35, CH_ETX, "?M"));
      expect_tx('{CH_ACK, 8'h30, 8'h35});
      respond(1'b1, " MAB", "AB", 0);
   endtask
   task automatic s_retry();
      send(frm(8'h30, 8'h35, CH_ETX, " h03"));
      expect_tx('{CH_ACK, 8'h30, 8'h35});
      respond(1'b1, "#", "", 6);
      chk(8'(n_rep), 8'h05);
      chk(8'(n_fail), 8'h01);
   endtask
   initial begin
      repeat (6) @(posedge clk_i);
      rst_n_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      s_ctrl();
      s_query();
      s_bad();
      s_bcast();
      s_other();
      s_qok();
      s_retry();
      end_sim();
   end
   // Cuts a hang short well after the expected run length.
   initial begin
      #200us;
      n_mismatch++;
      end_sim();
   end
endmodule
